// File: rtl/adc_serial_control.sv
// converter serial control: reset, start/sync, data-ready timing, timeout and gpio update
// What this block does
// - Data-ready rises 4 to 5 clocks after start rise or command's first edge.
// - Data-ready stays high at least 24 master clocks before falling.
// - Serial interface resets if a byte is not complete within 2^15 clocks.
// - Input sampled on serial clock falling edges, output changed after rising edges.
// - Serial output driven only while chip select is low.
// - General outputs update after the last falling edge of a write command.
`timescale 1ns/1ns
module adc_serial_control #(
	parameter int unsigned TIMEOUT_CYCLES = adc_pkg::SPI_TIMEOUT_CYC
) (
	// master clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	// serial link
	input  wire logic                       link_sclk,
	input  wire logic                       cs_n,
	input  wire logic                       din,
	output logic                            dout,
	output logic                            dout_oe,
	// conversion control pins
	input  wire logic                       reset_pin_n,
	input  wire logic                       start_sync,
	output logic                            data_ready_n,
	// general purpose outputs
	output logic [adc_pkg::GPIO_W-1:0]      general_io_pin
);
	localparam adc_pkg::cnt_t TOUT_LAST  = adc_pkg::cnt_t'(TIMEOUT_CYCLES - 1);
	localparam adc_pkg::cnt_t RST_LAST   = adc_pkg::cnt_t'(adc_pkg::RESET_LOW_MIN_CYC - 1);
	localparam adc_pkg::cnt_t RCV_LAST   = adc_pkg::cnt_t'(adc_pkg::RECOVER_CYC - 1);
	localparam adc_pkg::cnt_t HIGH_LAST  = adc_pkg::cnt_t'(adc_pkg::DATA_READY_N_HIGH_MIN_CYC - 1);
	localparam adc_pkg::cnt_t CONV_LAST  = adc_pkg::cnt_t'(adc_pkg::CONV_PERIOD_CYC - 1);
	localparam int            HIGH_MIN_I = adc_pkg::DATA_READY_N_HIGH_MIN_CYC - 1;

	sif_if sif ();

	sif_shifter u_shifter (
		.link_sclk (link_sclk),
		.din       (din),
		.dout      (dout),
		.sif       (sif.shift)
	);

	// saturating increment shared by the reset-width, timeout and high-time counters
	function automatic adc_pkg::cnt_t sat_inc(input adc_pkg::cnt_t v);
		sat_inc = (v == '1) ? v : v + 16'h0001;
	endfunction : sat_inc

	// three-stage synchronisers; a level counts once stages two and three agree
	logic [adc_pkg::SYNC_N-1:0] sync1_r, sync2_r, sync3_r, stable_r, stable_d_r;
	logic [adc_pkg::SYNC_N-1:0] stable_nxt;

	always_comb begin
		for (int i = 0; i < adc_pkg::SYNC_N; i++) begin
			stable_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : stable_r[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sync1_r    <= adc_pkg::SYNC_RST;
			sync2_r    <= adc_pkg::SYNC_RST;
			sync3_r    <= adc_pkg::SYNC_RST;
			stable_r   <= adc_pkg::SYNC_RST;
			stable_d_r <= adc_pkg::SYNC_RST;
		end else begin
			sync1_r    <= {sif.frame_tgl, sif.rx_tgl, cs_n, start_sync, reset_pin_n};
			sync2_r    <= sync1_r;
			sync3_r    <= sync2_r;
			stable_r   <= stable_nxt;
			stable_d_r <= stable_r;
		end
	end

	// decoded events from the synchronised lanes
	logic start_rise, start_fall, rx_evt, frame_evt, cs_active;
	assign start_rise = stable_r[adc_pkg::SY_START] & ~stable_d_r[adc_pkg::SY_START];
	assign start_fall = ~stable_r[adc_pkg::SY_START] & stable_d_r[adc_pkg::SY_START];
	assign rx_evt     = stable_r[adc_pkg::SY_RX] ^ stable_d_r[adc_pkg::SY_RX];
	assign frame_evt  = stable_r[adc_pkg::SY_FRAME] ^ stable_d_r[adc_pkg::SY_FRAME];
	assign cs_active  = ~stable_r[adc_pkg::SY_CS];

	// control state
	adc_pkg::conv_state_t          conv_state_r, conv_state_nxt;
	adc_pkg::cmd_state_t           cmd_state_r, cmd_state_nxt;
	adc_pkg::cnt_t                 rst_cnt_r, rst_cnt_nxt;
	adc_pkg::cnt_t                 rcv_cnt_r, rcv_cnt_nxt;
	adc_pkg::cnt_t                 conv_cnt_r, conv_cnt_nxt;
	adc_pkg::cnt_t                 high_cnt_r, high_cnt_nxt;
	adc_pkg::cnt_t                 tout_cnt_r, tout_cnt_nxt;
	logic                          done_pend_r, done_pend_nxt;
	logic                          data_ready_n_r, data_ready_n_nxt;
	logic                          spi_clr_r, spi_clr_nxt;
	logic [adc_pkg::DATA_W-1:0]    result_r, result_nxt;
	logic [adc_pkg::DATA_W-1:0]    tx_hold_r, tx_hold_nxt;
	logic [adc_pkg::GPIO_W-1:0]    gpio_r, gpio_nxt;

	// event terms visible to the checks below
	logic hw_reset, cmd_reset, cmd_start, cmd_stop, gpio_we, go_evt, halt_evt, tout_hit;
	logic byte_ok, conv_done;

	always_comb begin
		byte_ok   = rx_evt && (conv_state_r != adc_pkg::CONV_RECOVER);
		cmd_reset = byte_ok && (cmd_state_r == adc_pkg::CMD_OPCODE) &&
			(sif.rx_byte == adc_pkg::CMD_RESET);
		cmd_start = byte_ok && (cmd_state_r == adc_pkg::CMD_OPCODE) &&
			(sif.rx_byte == adc_pkg::CMD_START);
		cmd_stop  = byte_ok && (cmd_state_r == adc_pkg::CMD_OPCODE) &&
			(sif.rx_byte == adc_pkg::CMD_STOP);
		gpio_we   = byte_ok && (cmd_state_r == adc_pkg::CMD_GPIO_DATA);
		// reset pin must have been low for the minimum before it takes effect
		hw_reset  = ~stable_r[adc_pkg::SY_RESET] && (rst_cnt_r >= RST_LAST);
		tout_hit  = (tout_cnt_r == TOUT_LAST);
		go_evt    = start_rise || cmd_start;
		halt_evt  = start_fall || cmd_stop;
		conv_done = (conv_state_r == adc_pkg::CONV_RUN) && (conv_cnt_r == CONV_LAST);
	end

	// reset-pin low width, byte timeout, command state and general output update
	always_comb begin
		rst_cnt_nxt   = stable_r[adc_pkg::SY_RESET] ? '0 : sat_inc(rst_cnt_r);
		tout_cnt_nxt  = (cs_active && !rx_evt && !tout_hit) ? sat_inc(tout_cnt_r) : '0;
		spi_clr_nxt   = tout_hit || hw_reset || cmd_reset;
		cmd_state_nxt = cmd_state_r;
		gpio_nxt      = gpio_r;
		if (gpio_we) begin
			gpio_nxt      = sif.rx_byte[adc_pkg::GPIO_W-1:0];
			cmd_state_nxt = adc_pkg::CMD_OPCODE;
		end else if (byte_ok && (cmd_state_r == adc_pkg::CMD_OPCODE) &&
			(sif.rx_byte == adc_pkg::CMD_GPIO_WRITE)) begin
			cmd_state_nxt = adc_pkg::CMD_GPIO_DATA;
		end
		// a partial command is dropped along with the partial byte
		if (tout_hit || hw_reset || cmd_reset) begin
			cmd_state_nxt = adc_pkg::CMD_OPCODE;
		end
		if (hw_reset || cmd_reset) begin
			gpio_nxt = adc_pkg::GPIO_RST;
		end
	end

	// conversion sequencing and data-ready pulse
	always_comb begin
		conv_state_nxt   = conv_state_r;
		rcv_cnt_nxt      = rcv_cnt_r;
		conv_cnt_nxt     = conv_cnt_r;
		done_pend_nxt    = done_pend_r;
		result_nxt       = result_r;
		tx_hold_nxt      = tx_hold_r;
		data_ready_n_nxt = data_ready_n_r;
		high_cnt_nxt     = data_ready_n_r ? sat_inc(high_cnt_r) : '0;
		case (conv_state_r)
			adc_pkg::CONV_IDLE: begin
				if (go_evt) begin
					conv_state_nxt = adc_pkg::CONV_RUN;
					conv_cnt_nxt   = '0;
				end
			end
			adc_pkg::CONV_RUN: begin
				conv_cnt_nxt = conv_done ? '0 : conv_cnt_r + 16'h0001;
				if (conv_done) begin
					result_nxt    = result_r + 16'h0001;
					done_pend_nxt = 1'b1;
				end
				// stop is honoured the cycle it is seen; earlier than 32 clocks is safe
				if (halt_evt) begin
					conv_state_nxt = adc_pkg::CONV_IDLE;
					done_pend_nxt  = 1'b0;
				end else if (go_evt) begin
					conv_cnt_nxt = '0; // resynchronise
				end
			end
			adc_pkg::CONV_RECOVER: begin
				// frames are ignored until the host's wait has elapsed
				if (!stable_r[adc_pkg::SY_RESET]) begin
					rcv_cnt_nxt = '0;
				end else if (rcv_cnt_r == RCV_LAST) begin
					conv_state_nxt = adc_pkg::CONV_IDLE;
				end else begin
					rcv_cnt_nxt = rcv_cnt_r + 16'h0001;
				end
			end
			default: begin
				conv_state_nxt = adc_pkg::CONV_IDLE;
			end
		endcase
		// raise wins over a pending fall in the same cycle
		if (start_rise || frame_evt) begin
			data_ready_n_nxt = 1'b1;
		end else if (done_pend_nxt && data_ready_n_r && (high_cnt_r >= HIGH_LAST)) begin
			data_ready_n_nxt = 1'b0;
			done_pend_nxt    = 1'b0;
			tx_hold_nxt      = result_nxt;
		end
		if (hw_reset || cmd_reset) begin
			conv_state_nxt   = adc_pkg::CONV_RECOVER;
			rcv_cnt_nxt      = '0;
			done_pend_nxt    = 1'b0;
			data_ready_n_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			conv_state_r   <= adc_pkg::CONV_IDLE;
			cmd_state_r    <= adc_pkg::CMD_OPCODE;
			rst_cnt_r      <= '0;
			rcv_cnt_r      <= '0;
			conv_cnt_r     <= '0;
			high_cnt_r     <= '0;
			tout_cnt_r     <= '0;
			done_pend_r    <= 1'b0;
			data_ready_n_r <= 1'b1;
			spi_clr_r      <= 1'b1;
			result_r       <= '0;
			tx_hold_r      <= '0;
			gpio_r         <= adc_pkg::GPIO_RST;
		end else begin
			conv_state_r   <= conv_state_nxt;
			cmd_state_r    <= cmd_state_nxt;
			rst_cnt_r      <= rst_cnt_nxt;
			rcv_cnt_r      <= rcv_cnt_nxt;
			conv_cnt_r     <= conv_cnt_nxt;
			high_cnt_r     <= high_cnt_nxt;
			tout_cnt_r     <= tout_cnt_nxt;
			done_pend_r    <= done_pend_nxt;
			data_ready_n_r <= data_ready_n_nxt;
			spi_clr_r      <= spi_clr_nxt;
			result_r       <= result_nxt;
			tx_hold_r      <= tx_hold_nxt;
			gpio_r         <= gpio_nxt;
		end
	end

	// output word changes only at a data-ready fall, which may land inside a frame and change it under a read in progress
	assign sif.tx_word    = tx_hold_r;
	assign sif.clr        = spi_clr_r;
	// straight from the pin so release follows chip select without a clock
	assign dout_oe        = ~cs_n;
	assign data_ready_n   = data_ready_n_r;
	assign general_io_pin = gpio_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence recovering;
		conv_state_r == adc_pkg::CONV_RECOVER;
	endsequence

	sequence ready_raised;
		data_ready_n_r == 1'b1;
	endsequence

	chk_start_raises_ready: assert property (start_rise |=> ready_raised)
		else $error("data ready not raised after start edge");

	chk_frame_raises_ready: assert property (frame_evt |=> ready_raised)
		else $error("data ready not raised after command first edge");

	chk_ready_high_width: assert property ($fell(data_ready_n_r) |->
		$past(high_cnt_r) >= HIGH_MIN_I)
		else $error("data ready high phase too short");

	// the counter may restart one cycle after the clear while chip select stays low
	chk_timeout_clears_if: assert property (tout_hit |=> spi_clr_r && (tout_cnt_r == '0))
		else $error("byte timeout did not clear serial interface");

	sequence tout_edge;
		(tout_cnt_r == TOUT_LAST - 16'h0001) && cs_active && !rx_evt;
	endsequence

	chk_timeout_reached: assert property (tout_edge |=> tout_hit)
		else $error("byte timeout not reached after its full count");

	chk_timeout_limit: assert property (tout_cnt_r <= TOUT_LAST)
		else $error("timeout counter ran past its limit");

	chk_gpio_update: assert property (gpio_we && !hw_reset && !cmd_reset |=>
		general_io_pin == $past(sif.rx_byte[adc_pkg::GPIO_W-1:0]))
		else $error("general outputs not updated by write data");

	chk_gpio_steady: assert property (!gpio_we && !hw_reset && !cmd_reset |=>
		$stable(general_io_pin))
		else $error("general outputs changed without a write");

	chk_stop_halts: assert property (halt_evt && conv_state_r == adc_pkg::CONV_RUN &&
		!hw_reset && !cmd_reset |=> (conv_state_r == adc_pkg::CONV_IDLE) && !done_pend_r)
		else $error("stop did not halt conversions");

	chk_reset_recover: assert property (hw_reset || cmd_reset |=> recovering [*3])
		else $error("reset did not hold the recovery wait");

	chk_reset_low_width: assert property (hw_reset |->
		$past(~stable_r[adc_pkg::SY_RESET], 3))
		else $error("reset accepted from a short low pulse");

	// an accepted reset puts the general outputs back to their reset level
	chk_reset_gpio_clear: assert property (hw_reset |=> general_io_pin == adc_pkg::GPIO_RST)
		else $error("general outputs not cleared by reset");

	// bytes that land during the recovery wait must not reach the outputs
	chk_recover_ignores: assert property (recovering and rx_evt |=> $stable(general_io_pin))
		else $error("byte acted on during recovery");

	// a fall only ever follows a finished conversion
	chk_ready_fall_cause: assert property ($fell(data_ready_n_r) |->
		$past(conv_done || done_pend_r))
		else $error("data ready fell without a finished conversion");
endmodule : adc_serial_control

// File: rtl/adc_pkg.sv
// shared constants, commands and state types for the converter serial control block
package adc_pkg;
	// time base: one core_clk cycle is one master_clock_period
	localparam int    CYC_PER_MASTER_CLOCK_PERIOD       = 1;
	localparam int    RESET_LOW_MIN_MASTER_CLOCK_PERIOD = 4;
	localparam int    RESET_LOW_MIN_CYC  = RESET_LOW_MIN_MASTER_CLOCK_PERIOD * CYC_PER_MASTER_CLOCK_PERIOD;
	localparam int    RECOVER_MIN_MASTER_CLOCK_PERIOD   = 4096;
	localparam int    RECOVER_CYC        = RECOVER_MIN_MASTER_CLOCK_PERIOD * CYC_PER_MASTER_CLOCK_PERIOD;
	localparam int    DATA_READY_N_HIGH_MIN_MASTER_CLOCK_PERIOD = 24;
	localparam int    DATA_READY_N_HIGH_MIN_CYC  = DATA_READY_N_HIGH_MIN_MASTER_CLOCK_PERIOD * CYC_PER_MASTER_CLOCK_PERIOD;
	localparam int    SPI_TIMEOUT_MASTER_CLOCK_PERIOD   = 32768;
	localparam int    SPI_TIMEOUT_CYC    = SPI_TIMEOUT_MASTER_CLOCK_PERIOD * CYC_PER_MASTER_CLOCK_PERIOD;
	localparam int    CONV_PERIOD_MASTER_CLOCK_PERIOD   = 400;
	localparam int    CONV_PERIOD_CYC    = CONV_PERIOD_MASTER_CLOCK_PERIOD * CYC_PER_MASTER_CLOCK_PERIOD;

	// widths
	localparam int    CNT_W     = 16;
	localparam int    BYTE_W    = 8;
	localparam int    DATA_W    = 16;
	localparam int    GPIO_W    = 4;
	localparam int    BIT_CNT_W = 3;
	localparam int    OUT_IDX_W = 4;
	localparam int    SYNC_N    = 5;

	typedef logic [CNT_W-1:0] cnt_t;

	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [OUT_IDX_W-1:0] FIRST_OUT_IDX = 4'hF;

	// synchroniser lanes and their idle levels
	localparam int    SY_RESET = 0;
	localparam int    SY_START = 1;
	localparam int    SY_CS    = 2;
	localparam int    SY_RX    = 3;
	localparam int    SY_FRAME = 4;
	localparam logic [SYNC_N-1:0] SYNC_RST = 5'h05;

	// command opcodes
	localparam logic [BYTE_W-1:0] CMD_RESET      = 8'h06;
	localparam logic [BYTE_W-1:0] CMD_START      = 8'h08;
	localparam logic [BYTE_W-1:0] CMD_STOP       = 8'h0A;
	localparam logic [BYTE_W-1:0] CMD_READ_DATA  = 8'h12;
	localparam logic [BYTE_W-1:0] CMD_GPIO_WRITE = 8'h40;

	localparam logic [GPIO_W-1:0] GPIO_RST = 4'h0;

	typedef enum logic [2:0] {
		CONV_IDLE    = 3'b001,
		CONV_RUN     = 3'b010,
		CONV_RECOVER = 3'b100
	} conv_state_t;

	typedef enum logic [1:0] {
		CMD_OPCODE    = 2'b01,
		CMD_GPIO_DATA = 2'b10
	} cmd_state_t;
endpackage : adc_pkg

// File: rtl/sif_if.sv
// signals between the core-clock control and the serial-clock shifter
`timescale 1ns/1ns
interface sif_if;
	logic                             clr;
	logic [adc_pkg::BYTE_W-1:0]       rx_byte;
	logic                             rx_tgl;
	logic                             frame_tgl;
	logic [adc_pkg::DATA_W-1:0]       tx_word;

	modport core (output clr, output tx_word, input rx_byte, input rx_tgl, input frame_tgl);
	modport shift (input clr, input tx_word, output rx_byte, output rx_tgl, output frame_tgl);
endinterface : sif_if

// File: rtl/sif_shifter.sv
// serial-clock domain shifter: byte capture on falling edges, data out on rising edges
`timescale 1ns/1ns
module sif_shifter (
	// serial link
	input  wire logic link_sclk,
	input  wire logic din,
	output logic      dout,
	// core side
	sif_if.shift      sif
);
	logic [adc_pkg::BIT_CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
	logic [adc_pkg::BYTE_W-1:0]    rx_shift_r, rx_shift_nxt;
	logic [adc_pkg::BYTE_W-1:0]    rx_byte_r, rx_byte_nxt;
	logic                          rx_tgl_r, rx_tgl_nxt;
	logic                          frame_tgl_r, frame_tgl_nxt;
	logic [adc_pkg::OUT_IDX_W-1:0] out_idx_r, out_idx_nxt;
	logic                          dout_r, dout_nxt;

	// falling-edge capture; sclk may stop mid-byte so the core clears us asynchronously
	always_comb begin
		rx_shift_nxt = {rx_shift_r[adc_pkg::BYTE_W-2:0], din};
		bit_cnt_nxt  = bit_cnt_r + 3'h1;
		rx_byte_nxt  = rx_byte_r;
		rx_tgl_nxt   = rx_tgl_r;
		if (bit_cnt_r == adc_pkg::LAST_BIT) begin
			rx_byte_nxt = rx_shift_nxt;
			rx_tgl_nxt  = ~rx_tgl_r; // byte stays stable for eight more bits
		end
	end

	always_ff @(negedge link_sclk or posedge sif.clr) begin
		if (sif.clr) begin
			bit_cnt_r  <= '0;
			rx_shift_r <= '0;
			rx_byte_r  <= '0;
			rx_tgl_r   <= 1'b0;
		end else begin
			bit_cnt_r  <= bit_cnt_nxt;
			rx_shift_r <= rx_shift_nxt;
			rx_byte_r  <= rx_byte_nxt;
			rx_tgl_r   <= rx_tgl_nxt;
		end
	end

	// rising-edge launch, msb first; first rising edge of each byte flags a frame
	always_comb begin
		frame_tgl_nxt = (bit_cnt_r == '0) ? ~frame_tgl_r : frame_tgl_r;
		dout_nxt      = sif.tx_word[out_idx_r];
		out_idx_nxt   = out_idx_r - 4'h1;
	end

	always_ff @(posedge link_sclk or posedge sif.clr) begin
		if (sif.clr) begin
			frame_tgl_r <= 1'b0;
			out_idx_r   <= adc_pkg::FIRST_OUT_IDX;
			dout_r      <= 1'b0;
		end else begin
			frame_tgl_r <= frame_tgl_nxt;
			out_idx_r   <= out_idx_nxt;
			dout_r      <= dout_nxt;
		end
	end

	assign sif.rx_byte   = rx_byte_r;
	assign sif.rx_tgl    = rx_tgl_r;
	assign sif.frame_tgl = frame_tgl_r;
	assign dout          = dout_r;
endmodule : sif_shifter

// File: tb/host_model.sv
// host-side serial master model: chip select, gated serial clock and data in
`timescale 1ns/1ns
module host_model (
	// serial link
	output logic link_sclk,
	output logic cs_n,
	output logic din
);
	logic tick;

	// free phase reference; the clock pin itself only moves inside frames
	initial begin
		tick = 1'b0;
		link_sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		#7;
		forever #20 tick = ~tick;
	end

	// data launched with the rise, held 40 ns past the fall
	task automatic shift_bit(input logic b);
		@(posedge tick);
		link_sclk <= 1'b1;
		din <= b;
		@(posedge tick);
		link_sclk <= 1'b0;
	endtask : shift_bit

	// msb first, bytes may follow with no gap
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			shift_bit(b[i]);
		end
	endtask : send_byte

	// half a byte, to leave the receiver mid-byte
	task automatic send_nib(input logic [3:0] b);
		for (int i = 3; i >= 0; i--) begin
			shift_bit(b[i]);
		end
	endtask : send_nib

	task automatic frame_open();
		@(posedge tick);
		cs_n <= 1'b0;
	endtask : frame_open

	// released data line shows the inverse so a stale bit is never read as valid
	task automatic frame_close();
		@(posedge tick);
		cs_n <= 1'b1;
		din <= ~din;
	endtask : frame_close
endmodule : host_model

// File: tb/adc_serial_control_tb_top.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ns
module adc_serial_control_tb_top;
	// timeout well above one byte time (64 core cycles at this link rate)
	localparam int unsigned TMO = 200;
	logic       core_clk;
	logic       reset_n;
	logic       link_sclk;
	logic       cs_n;
	logic       din;
	logic       dout;
	logic       dout_oe;
	logic       reset_pin_n;
	logic       start_sync;
	logic       data_ready_n;
	logic [3:0] general_io_pin;
	logic [3:0] gpio_model;
	int         error_cnt;
	int         comparisons;

	adc_serial_control #(.TIMEOUT_CYCLES(TMO)) DUT (
		.core_clk(core_clk), .reset_n(reset_n), .link_sclk(link_sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.reset_pin_n(reset_pin_n), .start_sync(start_sync),
		.data_ready_n(data_ready_n), .general_io_pin(general_io_pin)
	);
	host_model host (.link_sclk(link_sclk), .cs_n(cs_n), .din(din));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	// settled sampling one ns after each edge
	task automatic wait_data_ready_n(input logic lvl, input int lim, output int n);
		n = 0;
		while (data_ready_n !== lvl && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask : wait_data_ready_n

	task automatic pin_reset(input int len);
		@(posedge core_clk) reset_pin_n <= 1'b0;
		repeat (len) @(posedge core_clk);
		reset_pin_n <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask : pin_reset

	// gpio must not move before the last fall, then show exp
	task automatic write_gpio(input logic [3:0] v, input logic [3:0] exp);
		host.send_byte(adc_pkg::CMD_GPIO_WRITE);
		host.send_byte({4'h0, v});
		chk("gpio before update", gpio_model, general_io_pin);
		repeat (10) @(posedge core_clk);
		chk("gpio", exp, general_io_pin);
		gpio_model = exp;
	endtask : write_gpio

	task automatic t_gpio();
		chk("dout_oe idle", 4'h0, {3'h0, dout_oe});
		host.frame_open();
		repeat (2) @(posedge core_clk);
		chk("dout_oe selected", 4'h1, {3'h0, dout_oe});
		write_gpio(4'hD, 4'hD);
		write_gpio(4'h2, 4'h2);
		host.frame_close();
		repeat (2) @(posedge core_clk);
		chk("dout_oe released", 4'h0, {3'h0, dout_oe});
	endtask : t_gpio

	// a dangling half byte must be dropped, else the next bytes misalign
	task automatic t_timeout();
		host.frame_open();
		host.send_nib(4'hA);
		repeat (TMO + 40) @(posedge core_clk);
		write_gpio(4'h5, 4'h5);
		host.frame_close();
	endtask : t_timeout

	task automatic t_reset_pin();
		pin_reset(2);
		chk("gpio short pulse", gpio_model, general_io_pin);
		pin_reset(8);
		chk("gpio after pin reset", adc_pkg::GPIO_RST, general_io_pin);
		chk("data_ready_n after pin reset", 4'h1, {3'h0, data_ready_n});
		gpio_model = adc_pkg::GPIO_RST;
		host.frame_open();
		write_gpio(4'h3, adc_pkg::GPIO_RST);
		host.frame_close();
		repeat (adc_pkg::RECOVER_CYC + 10) @(posedge core_clk);
		host.frame_open();
		write_gpio(4'h3, 4'h3);
		host.frame_close();
	endtask : t_reset_pin

	task automatic t_reset_cmd();
		host.frame_open();
		host.send_byte(adc_pkg::CMD_RESET);
		host.frame_close();
		repeat (10) @(posedge core_clk);
		chk("gpio after reset cmd", adc_pkg::GPIO_RST, general_io_pin);
		chk("dout after reset cmd", 4'h0, {3'h0, dout});
		gpio_model = adc_pkg::GPIO_RST;
		repeat (adc_pkg::RECOVER_CYC + 10) @(posedge core_clk);
		host.frame_open();
		write_gpio(4'h6, 4'h6);
		host.frame_close();
	endtask : t_reset_cmd

	task automatic t_start();
		int n;
		@(posedge core_clk) start_sync <= 1'b1;
		wait_data_ready_n(1'b0, adc_pkg::CONV_PERIOD_CYC + 40, n);
		chk("first conversion", 4'h0, {3'h0, data_ready_n});
		@(posedge core_clk) start_sync <= 1'b0;
		repeat (8) @(posedge core_clk);
		start_sync <= 1'b1;
		wait_data_ready_n(1'b1, 10, n);
		chk("start to data_ready_n", 4'h1, {3'h0, n <= 6});
		wait_data_ready_n(1'b0, adc_pkg::CONV_PERIOD_CYC + 40, n);
		chk("data_ready_n high time", 4'h1, {3'h0, n >= 24});
		chk("next conversion", 4'h0, {3'h0, data_ready_n});
	endtask : t_start

	// serial raise lands shortly before a completion, which must wait
	task automatic t_serial_raise();
		int n;
		repeat (adc_pkg::CONV_PERIOD_CYC - 30) @(posedge core_clk);
		host.frame_open();
		fork
			host.send_byte(adc_pkg::CMD_READ_DATA);
			begin
				@(posedge link_sclk);
				wait_data_ready_n(1'b1, 12, n);
				chk("sclk to data_ready_n", 4'h1, {3'h0, n <= 7});
				wait_data_ready_n(1'b0, 80, n);
				chk("high time at completion", 4'h1, {3'h0, n >= 24});
				chk("completion kept", 4'h0, {3'h0, data_ready_n});
			end
		join
		host.frame_close();
	endtask : t_serial_raise

	task automatic t_stop();
		int n;
		host.frame_open();
		host.send_byte(adc_pkg::CMD_STOP);
		host.frame_close();
		wait_data_ready_n(1'b0, adc_pkg::CONV_PERIOD_CYC + 60, n);
		chk("no conversion after stop", 4'h1, {3'h0, data_ready_n});
		start_sync <= 1'b0;
	endtask : t_stop

	task automatic summarize();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		error_cnt = 0;
		comparisons = 0;
		gpio_model = adc_pkg::GPIO_RST;
		reset_n = 1'b0;
		reset_pin_n = 1'b1;
		start_sync = 1'b0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("data_ready_n reset", 4'h1, {3'h0, data_ready_n});
		chk("gpio reset", adc_pkg::GPIO_RST, general_io_pin);
		t_gpio();
		t_timeout();
		t_reset_pin();
		t_reset_cmd();
		t_start();
		t_serial_raise();
		t_stop();
		summarize();
	end

	// watchdog: the sequence needs roughly 12000 cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		summarize();
	end
endmodule : adc_serial_control_tb_top
